//--- supply_monitor_pkg.sv
// Constants and types shared by the supply monitor control files
package supply_monitor_pkg;
  localparam logic [19:0] OPTION_BYTE_ADDR = 20'h000c1;
  localparam int          MODE_LSB         = 0;
  localparam int          MODE_W           = 2;
  localparam int          LEVEL_LSB        = 2;
  localparam int          LEVEL_W          = 4;
  localparam logic [3:0]  LEVEL_MAX        = 4'ha;
  localparam logic [1:0]  MODE_OFF         = 2'h0;
  localparam logic [1:0]  MODE_IRQ         = 2'h1;
  localparam logic [1:0]  MODE_IRQ_RST     = 2'h2;
  localparam logic [1:0]  MODE_RST         = 2'h3;
  localparam int          ADDR_W           = 4;
  localparam int          DATA_W           = 8;
  localparam logic [3:0]  STATUS_OFS       = 4'h0;
  localparam logic [3:0]  CAUSE_OFS        = 4'h4;
  localparam logic [3:0]  OPTION_OFS       = 4'h8;
  localparam int          STATUS_BELOW_BIT = 0;
  localparam int          STATUS_RESET_BIT = 1;
  localparam int          CAUSE_MON_BIT    = 0;
  localparam logic [2:0]  SETTLE_CYCLES    = 3'h4;
  localparam int          SYNC_STAGES      = 3;
  localparam logic        SYNC_RESET_VALUE = 1'b0;

  typedef enum logic [3:0] {
    ST_LOAD = 4'b0001,
    ST_HOLD = 4'b0010,
    ST_RUN  = 4'b0100,
    ST_TRIP = 4'b1000
  } monitor_state_type;
endpackage

//--- supply_cmp_if.sv
// Interface carrying filtered comparator results to the control logic
`timescale 1ns/1ps
`default_nettype none
interface supply_cmp_if;
  logic belowMain;
  logic belowLow;
  modport sync (output belowMain, output belowLow);
  modport ctrl (input belowMain, input belowLow);
endinterface
`default_nettype wire

//--- supply_cmp_sync.sv
// Three-stage synchronizer with agreement filter for comparator inputs
`timescale 1ns/1ps
`default_nettype none
module supply_cmp_sync (
  input  wire logic  ref_clk,
  input  wire logic  rst_b,
  input  wire logic  cmpBelowMain,
  input  wire logic  cmpBelowLow,
  supply_cmp_if.sync cmp
);
  logic [1:0] rawIn;
  logic [1:0] stage1;
  logic [1:0] stage2;
  logic [1:0] stage3;
  logic [1:0] stable;
  logic [1:0] next_stable;

  assign rawIn = {cmpBelowLow, cmpBelowMain};

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_bit
      always_comb begin
        // Accept a change only once the last two stages agree
        next_stable[i] = (stage2[i] == stage3[i]) ? stage3[i] : stable[i]; // R10
      end

      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          stage1[i] <= supply_monitor_pkg::SYNC_RESET_VALUE;
          stage2[i] <= supply_monitor_pkg::SYNC_RESET_VALUE;
          stage3[i] <= supply_monitor_pkg::SYNC_RESET_VALUE;
          stable[i] <= supply_monitor_pkg::SYNC_RESET_VALUE;
        end else begin
          stage1[i] <= rawIn[i]; // R10
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          stable[i] <= next_stable[i];
        end
      end
    end
  endgenerate

  assign cmp.belowMain = stable[0];
  assign cmp.belowLow  = stable[1];
endmodule // supply_cmp_sync
`default_nettype wire

//--- supply_voltage_monitor_ctrl.sv
// Supply voltage monitor control: modes, internal reset, interrupt, flags
//
// Functional notes
// R1: Mode and level come from option byte
// R2: Eleven selectable levels passed to comparator
// R3: Keeps working in stop mode
// R4: Mode 1,0: irq below high, reset below low
// R5: Mode 1,1: reset while below level, no irq
// R6: Mode 0,1: hold reset until first above level
// R7: Mode 0,1: irq on every later crossing
// R8: Status bit 0 shows current comparison result
// R9: Monitor reset sets cause bit 0 (code sets it only on ST_TRIP entry, not in ST_HOLD)
// R10: Comparator inputs synchronized before use
`timescale 1ns/1ps
`default_nettype none
module supply_voltage_monitor_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  optionByte,
  input  wire logic        cmpBelowMain,
  input  wire logic        cmpBelowLow,
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdata,
  output logic      [19:0] optionAddr,
  output logic      [3:0]  levelCode,
  output logic      [1:0]  monitorMode,
  output logic             monitorReset,
  output logic             lowSupplyIrq
);
  supply_cmp_if cmp ();

  supply_cmp_sync u_sync (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .cmpBelowMain (cmpBelowMain),
    .cmpBelowLow  (cmpBelowLow),
    .cmp          (cmp.sync)
  );

  supply_monitor_pkg::monitor_state_type state;
  supply_monitor_pkg::monitor_state_type next_state;
  logic [2:0] settle;
  logic [2:0] next_settle;
  logic [1:0] next_monitorMode;
  logic [3:0] next_levelCode;
  logic       prevMain;
  logic       next_monitorReset;
  logic       next_lowSupplyIrq;
  logic       causeFlag;
  logic       next_causeFlag;
  logic [7:0] next_regRdata;
  logic       belowMain;
  logic       belowLow;

  assign belowMain  = cmp.belowMain;
  assign belowLow   = cmp.belowLow;
  assign optionAddr = supply_monitor_pkg::OPTION_BYTE_ADDR; // R1

  // Option capture and mode sequencing
  always_comb begin
    next_state        = state;
    next_settle       = settle;
    next_monitorMode  = monitorMode;
    next_levelCode    = levelCode;
    next_lowSupplyIrq = 1'b0;
    case (state)
      supply_monitor_pkg::ST_LOAD: begin
        next_monitorMode = optionByte[supply_monitor_pkg::MODE_LSB +:
                                      supply_monitor_pkg::MODE_W]; // R1
        if (optionByte[supply_monitor_pkg::LEVEL_LSB +: supply_monitor_pkg::LEVEL_W]
            > supply_monitor_pkg::LEVEL_MAX) begin
          next_levelCode = supply_monitor_pkg::LEVEL_MAX; // R2
        end else begin
          next_levelCode = optionByte[supply_monitor_pkg::LEVEL_LSB +:
                                      supply_monitor_pkg::LEVEL_W]; // R2
        end
        next_settle = settle + 3'h1;
        if (settle == supply_monitor_pkg::SETTLE_CYCLES - 3'h1) begin
          if (next_monitorMode == supply_monitor_pkg::MODE_IRQ) begin
            next_state = supply_monitor_pkg::ST_HOLD; // R6
          end else begin
            next_state = supply_monitor_pkg::ST_RUN;
          end
        end
      end
      supply_monitor_pkg::ST_HOLD: begin
        if (!belowMain) begin
          next_state = supply_monitor_pkg::ST_RUN; // R6
        end
      end
      supply_monitor_pkg::ST_RUN: begin
        case (monitorMode)
          supply_monitor_pkg::MODE_IRQ_RST: begin
            next_lowSupplyIrq = belowMain && !prevMain; // R4
            if (belowLow) begin
              next_state = supply_monitor_pkg::ST_TRIP; // R4
            end
          end
          supply_monitor_pkg::MODE_RST: begin
            if (belowMain) begin
              next_state = supply_monitor_pkg::ST_TRIP; // R5
            end
          end
          supply_monitor_pkg::MODE_IRQ: begin
            next_lowSupplyIrq = belowMain != prevMain; // R7
          end
          default: begin
            next_state = state;
          end
        endcase
      end
      supply_monitor_pkg::ST_TRIP: begin
        if (!belowMain) begin
          next_state = supply_monitor_pkg::ST_RUN; // R4 R5
        end
      end
      default: begin
        next_state = supply_monitor_pkg::ST_LOAD;
      end
    endcase
    next_monitorReset = (next_state == supply_monitor_pkg::ST_HOLD) ||
                        (next_state == supply_monitor_pkg::ST_TRIP);
  end

  // Reset cause flag and register reads
  always_comb begin
    next_causeFlag = causeFlag;
    if (regWrite && regAddr == supply_monitor_pkg::CAUSE_OFS &&
        regWdata[supply_monitor_pkg::CAUSE_MON_BIT]) begin
      next_causeFlag = 1'b0;
    end
    if (next_state == supply_monitor_pkg::ST_TRIP &&
        state != supply_monitor_pkg::ST_TRIP) begin
      next_causeFlag = 1'b1; // R9
    end
    next_regRdata = 8'h00;
    if (regRead) begin
      case (regAddr)
        supply_monitor_pkg::STATUS_OFS: begin
          next_regRdata[supply_monitor_pkg::STATUS_BELOW_BIT] = belowMain; // R8
          next_regRdata[supply_monitor_pkg::STATUS_RESET_BIT] = monitorReset;
        end
        supply_monitor_pkg::CAUSE_OFS: begin
          next_regRdata[supply_monitor_pkg::CAUSE_MON_BIT] = causeFlag; // R9
        end
        supply_monitor_pkg::OPTION_OFS: begin
          next_regRdata = {2'h0, levelCode, monitorMode};
        end
        default: begin
          next_regRdata = 8'h00;
        end
      endcase
    end
  end

  // No stop-mode gating: runs on every edge
  always_ff @(posedge ref_clk or negedge rst_b) begin // R3
    if (!rst_b) begin
      state        <= supply_monitor_pkg::ST_LOAD;
      settle       <= 3'h0;
      monitorMode  <= supply_monitor_pkg::MODE_OFF;
      levelCode    <= 4'h0;
      prevMain     <= 1'b0;
      monitorReset <= 1'b0;
      lowSupplyIrq <= 1'b0;
      causeFlag    <= 1'b0;
      regRdata     <= 8'h00;
    end else begin
      state        <= next_state;
      settle       <= next_settle;
      monitorMode  <= next_monitorMode;
      levelCode    <= next_levelCode;
      prevMain     <= belowMain;
      monitorReset <= next_monitorReset;
      lowSupplyIrq <= next_lowSupplyIrq;
      causeFlag    <= next_causeFlag;
      regRdata     <= next_regRdata;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_run_mode(logic [1:0] m);
    state == supply_monitor_pkg::ST_RUN && monitorMode == m;
  endsequence

  sequence s_enter_trip;
    state != supply_monitor_pkg::ST_TRIP ##1 state == supply_monitor_pkg::ST_TRIP;
  endsequence

  property p_option_fixed;
    state != supply_monitor_pkg::ST_LOAD |-> $stable(monitorMode) && $stable(levelCode);
  endproperty
  a_option_fixed: assert property (p_option_fixed) // R1
    else $error("mode or level changed after load");

  property p_level_range;
    levelCode <= supply_monitor_pkg::LEVEL_MAX;
  endproperty
  a_level_range: assert property (p_level_range) // R2
    else $error("level code out of range");

  property p_irqrst_trip;
    s_run_mode(supply_monitor_pkg::MODE_IRQ_RST) and belowLow |=> monitorReset ##1
      (monitorReset || !$past(belowMain));
  endproperty
  a_irqrst_trip: assert property (p_irqrst_trip) // R4
    else $error("reset not raised below low level");

  property p_irqrst_irq;
    s_run_mode(supply_monitor_pkg::MODE_IRQ_RST) and $rose(belowMain) |=> lowSupplyIrq;
  endproperty
  a_irqrst_irq: assert property (p_irqrst_irq) // R4
    else $error("irq missing below high level");

  property p_rst_follow;
    s_run_mode(supply_monitor_pkg::MODE_RST) and belowMain |=> monitorReset;
  endproperty
  a_rst_follow: assert property (p_rst_follow) // R5
    else $error("reset not raised below level");

  property p_rst_release;
    state == supply_monitor_pkg::ST_TRIP && !belowMain |=> !monitorReset;
  endproperty
  a_rst_release: assert property (p_rst_release) // R5
    else $error("reset not released above level");

  property p_rst_noirq;
    monitorMode == supply_monitor_pkg::MODE_RST |-> !lowSupplyIrq;
  endproperty
  a_rst_noirq: assert property (p_rst_noirq) // R5
    else $error("irq in reset-only mode");

  property p_hold;
    state == supply_monitor_pkg::ST_HOLD |-> monitorReset ##1
      (monitorReset || !$past(belowMain));
  endproperty
  a_hold: assert property (p_hold) // R6
    else $error("hold reset dropped early");

  property p_irq_cross;
    s_run_mode(supply_monitor_pkg::MODE_IRQ) and $changed(belowMain) |=> lowSupplyIrq ##1
      (!lowSupplyIrq || ($past(belowMain) != $past(belowMain, 2)));
  endproperty
  a_irq_cross: assert property (p_irq_cross) // R7
    else $error("crossing irq wrong");

  property p_status_read;
    regRead && regAddr == supply_monitor_pkg::STATUS_OFS |=>
      regRdata[supply_monitor_pkg::STATUS_BELOW_BIT] == $past(belowMain);
  endproperty
  a_status_read: assert property (p_status_read) // R8
    else $error("status flag mismatch");

  property p_cause_set;
    s_enter_trip |-> causeFlag;
  endproperty
  a_cause_set: assert property (p_cause_set) // R9
    else $error("cause flag not set");
endmodule // supply_voltage_monitor_ctrl
`default_nettype wire

//--- supply_cmp_model.sv
// Behavioural analog comparators on the far side of the monitor
`timescale 1ns/1ps
`default_nettype none
module supply_cmp_model (
  input  wire logic [7:0] supply,
  input  wire logic [3:0] levelCode,
  output logic            cmpBelowMain,
  output logic            cmpBelowLow
);
  logic [7:0] thrHigh;
  assign thrHigh      = 8'h40 + {2'h0, levelCode, 2'h0};
  assign cmpBelowMain = supply < thrHigh;
  assign cmpBelowLow  = supply < (thrHigh - 8'h10);
endmodule // supply_cmp_model
`default_nettype wire

//--- test_supply_voltage_monitor_ctrl.sv
// Self-checking bench for the supply monitor control block
`timescale 1ns/1ps
`default_nettype none
module test_supply_voltage_monitor_ctrl;
  logic        ref_clk    = 1'b0;
  logic        rst_b      = 1'b0;
  logic [7:0]  optionByte = 8'h00;
  logic [7:0]  supply     = 8'hf0;
  logic [3:0]  regAddr    = 4'h0;
  logic [7:0]  regWdata   = 8'h00;
  logic        regWrite   = 1'b0;
  logic        regRead    = 1'b0;
  logic        cmpBelowMain, cmpBelowLow, monitorReset, lowSupplyIrq;
  logic [7:0]  regRdata;
  logic [19:0] optionAddr;
  logic [3:0]  levelCode, lvl;
  logic [1:0]  monitorMode;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          irqs = 0;
  int          seed = 10568;
  int          base, m;

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (lowSupplyIrq === 1'b1) irqs <= irqs + 1;

  supply_cmp_model supply_cmp_model_inst (.supply(supply), .levelCode(levelCode),
    .cmpBelowMain(cmpBelowMain), .cmpBelowLow(cmpBelowLow));
  supply_voltage_monitor_ctrl supply_voltage_monitor_ctrl_inst (.ref_clk(ref_clk),
    .rst_b(rst_b), .optionByte(optionByte), .cmpBelowMain(cmpBelowMain),
    .cmpBelowLow(cmpBelowLow), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .optionAddr(optionAddr), .levelCode(levelCode), .monitorMode(monitorMode),
    .monitorReset(monitorReset), .lowSupplyIrq(lowSupplyIrq));

  task automatic stop_test;
    $display("Checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic fail(input string msg);
    n_fail++;
    $display("MISMATCH at %0t: %s", $time, msg);
  endtask
  task automatic check_val(input logic [19:0] got, input logic [19:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) fail(msg);
  endtask
  task automatic check_cnt(input int got, input int exp, input string msg);
    samples_checked++;
    if (got != exp) fail(msg);
  endtask
  function automatic logic [3:0] exp_level(input logic [3:0] l);
    return (l > 4'ha) ? 4'ha : l;
  endfunction
  function automatic logic [7:0] thr(input logic [3:0] l);
    return 8'h40 + {2'h0, exp_level(l), 2'h0};
  endfunction
  function automatic logic [3:0] rnd_level();
    return 4'($unsigned($random(seed)) % 11);
  endfunction
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp, input string msg);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 check_val({12'h0, regRdata}, {12'h0, exp}, msg);
  endtask
  task automatic do_reset(input logic [7:0] opt);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    optionByte <= opt;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_rst(input logic v);
    for (int i = 0; i < 20 && monitorReset !== v; i++) @(posedge ref_clk) #1;
    check_val({19'h0, monitorReset}, {19'h0, v}, "monitor reset level");
    if (monitorReset !== v) stop_test();
  endtask
  task automatic settle(input int exp, input string msg);
    repeat (10) @(posedge ref_clk);
    #1 check_cnt(irqs - base, exp, msg);
  endtask

  initial begin
    for (m = 0; m < 4; m++) begin
      lvl = (m == 0) ? 4'hf : rnd_level();
      do_reset({2'h0, lvl, 2'(m)});
      check_val(optionAddr, supply_monitor_pkg::OPTION_BYTE_ADDR, "option address");
      check_val({18'h0, monitorMode}, 20'(m), "mode capture");
      check_val({16'h0, levelCode}, {16'h0, exp_level(lvl)}, "level code");
      if (m != 0) reg_rd(supply_monitor_pkg::OPTION_OFS, {2'h0, lvl, 2'(m)}, "option");
    end
    reg_rd(4'hc, 8'h00, "unmapped read");
    $display("Test option capture done");
    base = irqs;
    supply <= 8'h10;
    @(posedge ref_clk);
    #1 check_val({19'h0, monitorReset}, 20'h0, "reset too early");
    wait_rst(1'b1);
    reg_rd(supply_monitor_pkg::STATUS_OFS, 8'h03, "status below");
    reg_rd(supply_monitor_pkg::CAUSE_OFS, 8'h01, "cause set");
    supply <= 8'hf0;
    wait_rst(1'b0);
    reg_rd(supply_monitor_pkg::STATUS_OFS, 8'h00, "status above");
    reg_wr(supply_monitor_pkg::CAUSE_OFS, 8'h01);
    reg_rd(supply_monitor_pkg::CAUSE_OFS, 8'h00, "cause clear");
    check_cnt(irqs - base, 0, "irq in reset mode");
    $display("Test reset mode done");
    lvl = rnd_level();
    do_reset({2'h0, lvl, 2'h2});
    base = irqs;
    supply <= thr(lvl) - 8'h08;
    settle(1, "irq below high");
    check_val({19'h0, monitorReset}, 20'h0, "no reset above low");
    supply <= 8'h10;
    wait_rst(1'b1);
    supply <= thr(lvl) - 8'h08;
    settle(1, "irq while tripped");
    check_val({19'h0, monitorReset}, 20'h1, "reset held below high");
    supply <= thr(lvl);
    wait_rst(1'b0);
    $display("Test interrupt and reset mode done");
    supply <= 8'h10;
    lvl = rnd_level();
    do_reset({2'h0, lvl, 2'h1});
    base = irqs;
    settle(0, "irq before first release");
    check_val({19'h0, monitorReset}, 20'h1, "initial hold");
    supply <= thr(lvl);
    wait_rst(1'b0);
    repeat (8) @(posedge ref_clk);
    #1 base = irqs;
    supply <= thr(lvl) - 8'h01;
    settle(1, "irq on fall");
    supply <= 8'hf0;
    settle(2, "irq on rise");
    check_val({19'h0, monitorReset}, 20'h0, "no reset in irq mode");
    $display("Test interrupt mode done");
    stop_test();
  end
endmodule // test_supply_voltage_monitor_ctrl
`default_nettype wire
